// file: core/tlbm_defs.vh
// constants for the translation buffer reload assist and invalidate block
`ifndef TLBM_DEFS_VH
`define TLBM_DEFS_VH
`define TLBM_OFF_ICTR 8'h00
`define TLBM_OFF_DCTR 8'h04
`define TLBM_OFF_IMISS 8'h08
`define TLBM_OFF_DMISS 8'h0C
`define TLBM_OFF_IRPN 8'h10
`define TLBM_OFF_DRPN 8'h14
`define TLBM_OFF_L1PTR 8'h18
`define TLBM_OFF_DTWC 8'h1C
`define TLBM_OFF_SCRATCH 8'h20
`define TLBM_OFF_STATUS 8'h24
`define TLBM_OFF_CMD 8'h28
`define TLBM_OFF_INVADDR 8'h2C
`define TLBM_OFF_MODE 8'h30
`define TLBM_RESP_OKAY 2'h0
`define TLBM_RESP_DECERR 2'h3
`define TLBM_RSV_TOP 5'h05
`define TLBM_FULL_TOP 5'h1F
`define TLBM_SPARE_LO 5'h1E
`define TLBM_MASK_4K_ACC 22'h3FFFFC
`define TLBM_MASK_4K_INV 22'h3FFFFF
`define TLBM_MASK_16K 22'h3FFFF0
`define TLBM_MASK_512K 22'h3FFE00
`define TLBM_MASK_8M 22'h3FE000
`define TLBM_PS_16K 2'h1
`define TLBM_PS_512K 2'h2
`define TLBM_PS_8M 2'h3
`define TLBM_MISS_VALID_BIT 9
`define TLBM_ATTR_TVALID 3
`define TLBM_ATTR_CHANGE 4
`define TLBM_ATTR_UREAD 5
`define TLBM_ATTR_UWRITE 6
`define TLBM_ATTR_SWRITE 7
`define TLBM_ST_INVALID 0
`define TLBM_ST_PROT 1
`define TLBM_ST_CHANGE 2
`define TLBM_ST_DMISS 3
`define TLBM_ST_IMISS 4
`define TLBM_CMD_INV_ALL 0
`define TLBM_CMD_INV_ONE 1
`endif

// file: core/tlbm_reload.v
// translation buffer reload assist, error check and invalidate logic with an axi4-lite slave
`include "tlbm_defs.vh"
`default_nettype none
module tlbm_reload (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire data_acc_valid,
	input wire [31:0] data_acc_addr,
	input wire data_acc_write,
	input wire data_acc_user,
	input wire fetch_valid,
	input wire [31:0] fetch_addr,
	output reg data_done,
	output reg [31:0] data_phys_addr,
	output reg data_miss,
	output reg data_error,
	output reg fetch_done,
	output reg [31:0] fetch_phys_addr,
	output reg fetch_miss
);

	// entry arrays: 0..31 instruction side, 32..63 data side; no reset on purpose
	reg ent_v [0:63];
	reg [21:0] ent_epn [0:63];
	reg [1:0] ent_ps [0:63];
	reg [19:0] ent_rpn [0:63];
	reg [7:0] ent_attr [0:63];

	reg aw_got_reg, w_got_reg;
	reg [7:0] aw_addr_reg;
	reg [31:0] w_data_reg;
	reg [3:0] w_strb_reg;
	reg instr_reserve_enable, data_reserve_enable;
	reg [4:0] instr_entry_index, data_entry_index;
	reg [31:0] instr_miss_page_reg, data_miss_page_reg;
	reg [19:0] l1_base_reg;
	reg [31:0] data_tablewalk_control_reg;
	reg [31:0] tablewalk_scratch_reg;
	reg [4:0] status_reg;
	reg [21:0] inv_addr_reg;
	reg instr_translation_on, data_translation_on;

	wire aw_take = s_axi_awvalid & s_axi_awready;
	wire w_take = s_axi_wvalid & s_axi_wready;
	wire ar_take = s_axi_arvalid & s_axi_arready;
	wire wr_fire = aw_got_reg & w_got_reg & ~s_axi_bvalid;
	wire [31:0] wr_val = w_data_reg;
	wire wr_ictr = wr_fire & (aw_addr_reg == `TLBM_OFF_ICTR);
	wire wr_dctr = wr_fire & (aw_addr_reg == `TLBM_OFF_DCTR);
	wire wr_irpn = wr_fire & (aw_addr_reg == `TLBM_OFF_IRPN);
	wire wr_drpn = wr_fire & (aw_addr_reg == `TLBM_OFF_DRPN);
	wire wr_cmd = wr_fire & (aw_addr_reg == `TLBM_OFF_CMD);
	wire inv_all = wr_cmd & wr_val[`TLBM_CMD_INV_ALL];
	wire inv_one = wr_cmd & wr_val[`TLBM_CMD_INV_ONE];

	// page match; invalidation keeps all 22 bits for 4K pages, lookups use 20
	function epn_hit;
		input [21:0] a;
		input [21:0] e;
		input [1:0] ps;
		input inv;
		reg [21:0] m;
		begin
			case (ps)
				`TLBM_PS_16K: m = `TLBM_MASK_16K;
				`TLBM_PS_512K: m = `TLBM_MASK_512K;
				`TLBM_PS_8M: m = `TLBM_MASK_8M;
				default: m = inv ? `TLBM_MASK_4K_INV : `TLBM_MASK_4K_ACC;
			endcase
			epn_hit = ((a ^ e) & m) == 22'h000000;
		end
	endfunction

	// byte-lane merge of a write into a stored word
	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] strb;
		integer k;
		begin
			merge = old;
			for (k = 0; k < 4; k = k + 1) begin
				if (strb[k])
					merge[k*8 +: 8] = nw[k*8 +: 8];
			end
		end
	endfunction

	// decrement with wrap to the top of the allowed range
	function [4:0] ctr_dec;
		input [4:0] c;
		input rsv;
		begin
			if (rsv && (c == 5'h00 || c > `TLBM_RSV_TOP))
				ctr_dec = `TLBM_RSV_TOP;
			else if (c == 5'h00)
				ctr_dec = `TLBM_FULL_TOP;
			else
				ctr_dec = c - 5'h01;
		end
	endfunction

	// victim choice on a miss: stay inside the first six entries while reserving
	function [4:0] ctr_clamp;
		input [4:0] c;
		input rsv;
		begin
			ctr_clamp = (rsv && c > `TLBM_RSV_TOP) ? `TLBM_RSV_TOP : c;
		end
	endfunction

	// level-two index scaled by the page size held in the tablewalk word
	function [9:0] l2_idx;
		input [21:0] epn;
		input [1:0] ps;
		begin
			case (ps)
				`TLBM_PS_512K: l2_idx = {epn[11:9], 7'h00};
				`TLBM_PS_8M: l2_idx = 10'h000;
				default: l2_idx = epn[11:2];
			endcase
		end
	endfunction

	// parallel lookup of both buffers; tag is not part of any match
	reg d_hit, i_hit;
	reg [5:0] d_idx, i_idx;
	integer n;
	always @* begin
		d_hit = 1'b0;
		i_hit = 1'b0;
		d_idx = 6'h00;
		i_idx = 6'h00;
		for (n = 0; n < 32; n = n + 1) begin
			if (ent_v[n + 32] && epn_hit(data_acc_addr[31:10], ent_epn[n + 32], ent_ps[n + 32], 1'b0)) begin
				d_hit = 1'b1;
				d_idx = n[5:0] + 6'h20;
			end
			if (ent_v[n] && epn_hit(fetch_addr[31:10], ent_epn[n], ent_ps[n], 1'b0)) begin
				i_hit = 1'b1;
				i_idx = n[5:0];
			end
		end
	end

	// access checks on the hitting data entry
	wire [7:0] d_attr = ent_attr[d_idx];
	wire d_go = data_acc_valid & data_translation_on;
	wire d_miss_now = d_go & ~d_hit;
	wire d_bad_valid = d_go & d_hit & ~d_attr[`TLBM_ATTR_TVALID];
	wire d_bad_prot = d_go & d_hit & d_attr[`TLBM_ATTR_TVALID] &
		(data_acc_user ? (data_acc_write ? ~d_attr[`TLBM_ATTR_UWRITE] : ~d_attr[`TLBM_ATTR_UREAD])
		: (data_acc_write & ~d_attr[`TLBM_ATTR_SWRITE]));
	wire d_bad_chg = d_go & d_hit & d_attr[`TLBM_ATTR_TVALID] & data_acc_write &
		~d_attr[`TLBM_ATTR_CHANGE];
	wire i_miss_now = fetch_valid & instr_translation_on & ~i_hit;

	// write address and data are taken in either order; response once both are held
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `TLBM_RESP_OKAY;
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
		end else begin
			if (aw_take) begin
				aw_got_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (w_take) begin
				w_got_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				aw_got_reg <= 1'b0;
				w_got_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr_reg > `TLBM_OFF_MODE || aw_addr_reg[1:0] != 2'h0) ?
					`TLBM_RESP_DECERR : `TLBM_RESP_OKAY;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// read data selection; pointers are built at read time from live state
	reg [31:0] rd_data;
	reg rd_err;
	always @* begin
		rd_err = 1'b0;
		case (s_axi_araddr)
			`TLBM_OFF_ICTR: rd_data = {19'h00000, instr_entry_index, 7'h00, instr_reserve_enable};
			`TLBM_OFF_DCTR: rd_data = {19'h00000, data_entry_index, 7'h00, data_reserve_enable};
			`TLBM_OFF_IMISS: rd_data = instr_miss_page_reg;
			`TLBM_OFF_DMISS: rd_data = data_miss_page_reg;
			`TLBM_OFF_L1PTR: rd_data = {l1_base_reg, data_miss_page_reg[31:22], 2'h0};
			`TLBM_OFF_DTWC: rd_data = {data_tablewalk_control_reg[31:12],
				l2_idx(data_miss_page_reg[31:10], data_tablewalk_control_reg[3:2]), 2'h0};
			`TLBM_OFF_SCRATCH: rd_data = tablewalk_scratch_reg;
			`TLBM_OFF_STATUS: rd_data = {27'h0000000, status_reg};
			`TLBM_OFF_INVADDR: rd_data = {inv_addr_reg, 10'h000};
			`TLBM_OFF_MODE: rd_data = {30'h00000000, data_translation_on, instr_translation_on};
			`TLBM_OFF_IRPN, `TLBM_OFF_DRPN, `TLBM_OFF_CMD: rd_data = 32'h00000000;
			default: begin
				rd_data = 32'h00000000;
				rd_err = 1'b1;
			end
		endcase
	end

	// read channel: one read in flight, answer one cycle after the address is taken
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `TLBM_RESP_OKAY;
		end else if (ar_take) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_data;
			s_axi_rresp <= rd_err ? `TLBM_RESP_DECERR : `TLBM_RESP_OKAY;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// software registers, replacement counters, miss capture and status
	always @(posedge aclk) begin
		if (!aresetn) begin
			instr_translation_on <= 1'b0;
			data_translation_on <= 1'b0;
			instr_reserve_enable <= 1'b0;
			data_reserve_enable <= 1'b0;
			instr_entry_index <= 5'h00;
			data_entry_index <= 5'h00;
			instr_miss_page_reg <= 32'h00000000;
			data_miss_page_reg <= 32'h00000000;
			l1_base_reg <= 20'h00000;
			data_tablewalk_control_reg <= 32'h00000000;
			tablewalk_scratch_reg <= 32'h00000000;
			status_reg <= 5'h00;
			inv_addr_reg <= 22'h000000;
		end else begin
			if (wr_fire) begin
				case (aw_addr_reg)
					`TLBM_OFF_IMISS: instr_miss_page_reg <= merge(instr_miss_page_reg, wr_val, w_strb_reg);
					`TLBM_OFF_DMISS: data_miss_page_reg <= merge(data_miss_page_reg, wr_val, w_strb_reg);
					`TLBM_OFF_L1PTR: l1_base_reg <= wr_val[31:12];
					`TLBM_OFF_DTWC: data_tablewalk_control_reg <= merge(data_tablewalk_control_reg,
						wr_val, w_strb_reg);
					`TLBM_OFF_SCRATCH: tablewalk_scratch_reg <= merge(tablewalk_scratch_reg,
						wr_val, w_strb_reg);
					`TLBM_OFF_INVADDR: inv_addr_reg <= wr_val[31:10];
					`TLBM_OFF_MODE: begin
						instr_translation_on <= wr_val[0];
						data_translation_on <= wr_val[1];
					end
					default: ;
				endcase
			end
			// control word: a software write beats the counter update in the same cycle
			if (wr_ictr) begin
				instr_reserve_enable <= wr_val[0];
				instr_entry_index <= wr_val[12:8];
			end else if (inv_all)
				instr_entry_index <= 5'h00;
			else if (wr_irpn)
				instr_entry_index <= ctr_dec(instr_entry_index, instr_reserve_enable);
			else if (i_miss_now)
				instr_entry_index <= ctr_clamp(instr_entry_index, instr_reserve_enable);
			if (wr_dctr) begin
				data_reserve_enable <= wr_val[0];
				data_entry_index <= wr_val[12:8];
			end else if (inv_all)
				data_entry_index <= 5'h00;
			else if (wr_drpn)
				data_entry_index <= ctr_dec(data_entry_index, data_reserve_enable);
			else if (d_miss_now)
				data_entry_index <= ctr_clamp(data_entry_index, data_reserve_enable);
			// miss capture: page, valid bit set as default, software tag kept
			if (d_miss_now)
				data_miss_page_reg <= {data_acc_addr[31:10], 1'b1, data_miss_page_reg[8:0]};
			if (i_miss_now)
				instr_miss_page_reg <= {fetch_addr[31:10], 1'b1, instr_miss_page_reg[8:0]};
			// sticky cause bits: write one to clear, a new event in the same cycle wins
			status_reg <= ((wr_fire && aw_addr_reg == `TLBM_OFF_STATUS) ?
				(status_reg & ~wr_val[4:0]) : status_reg) |
				{i_miss_now, d_miss_now, d_bad_chg, d_bad_prot, d_bad_valid};
		end
	end

	// entry writes and invalidation; the arrays keep their contents through reset
	integer j;
	always @(posedge aclk) begin
		if (wr_irpn) begin
			ent_v[{1'b0, instr_entry_index}] <= instr_miss_page_reg[`TLBM_MISS_VALID_BIT];
			ent_epn[{1'b0, instr_entry_index}] <= instr_miss_page_reg[31:10];
			ent_ps[{1'b0, instr_entry_index}] <= wr_val[9:8];
			ent_rpn[{1'b0, instr_entry_index}] <= wr_val[31:12];
			ent_attr[{1'b0, instr_entry_index}] <= wr_val[7:0];
		end
		if (wr_drpn) begin
			ent_v[{1'b1, data_entry_index}] <= data_miss_page_reg[`TLBM_MISS_VALID_BIT];
			ent_epn[{1'b1, data_entry_index}] <= data_miss_page_reg[31:10];
			ent_ps[{1'b1, data_entry_index}] <= wr_val[9:8];
			ent_rpn[{1'b1, data_entry_index}] <= wr_val[31:12];
			ent_attr[{1'b1, data_entry_index}] <= wr_val[7:0];
		end
		for (j = 0; j < 64; j = j + 1) begin
			if (inv_one && epn_hit(inv_addr_reg, ent_epn[j], ent_ps[j], 1'b1))
				ent_v[j] <= 1'b0;
			if (inv_all && !(j[4:0] >= `TLBM_SPARE_LO &&
				(j[5] ? data_reserve_enable : instr_reserve_enable)))
				ent_v[j] <= 1'b0;
		end
	end

	// access results: pulses one cycle after the request, real mode passes through
	always @(posedge aclk) begin
		if (!aresetn) begin
			data_done <= 1'b0;
			data_phys_addr <= 32'h00000000;
			data_miss <= 1'b0;
			data_error <= 1'b0;
			fetch_done <= 1'b0;
			fetch_phys_addr <= 32'h00000000;
			fetch_miss <= 1'b0;
		end else begin
			data_done <= data_acc_valid;
			data_miss <= d_miss_now;
			data_error <= d_bad_valid | d_bad_prot | d_bad_chg;
			data_phys_addr <= (data_translation_on && d_hit) ?
				{ent_rpn[d_idx], data_acc_addr[11:0]} : data_acc_addr;
			fetch_done <= fetch_valid;
			fetch_miss <= i_miss_now;
			fetch_phys_addr <= (instr_translation_on && i_hit) ?
				{ent_rpn[i_idx], fetch_addr[11:0]} : fetch_addr;
		end
	end

endmodule
`default_nettype wire

// file: verif/tlbm_core_model.sv
// core-side model: issues one-cycle data and fetch requests
`default_nettype none
module tlbm_core_model (
	input wire logic aclk,
	output logic data_acc_valid,
	output logic [31:0] data_acc_addr,
	output logic data_acc_write,
	output logic data_acc_user,
	output logic fetch_valid,
	output logic [31:0] fetch_addr
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		data_acc_valid = 1'b0;
		data_acc_addr = 32'h0;
		data_acc_write = 1'b0;
		data_acc_user = 1'b0;
		fetch_valid = 1'b0;
		fetch_addr = 32'h0;
	end
	// lines show the inverse after a request so a stale address can never hit
	task automatic access(input logic [31:0] a, input logic w, input logic u, input logic f);
		if (f) begin
			fetch_valid <= 1'b1;
			fetch_addr <= a;
		end else begin
			data_acc_valid <= 1'b1;
			data_acc_addr <= a;
			data_acc_write <= w;
			data_acc_user <= u;
		end
		@(posedge aclk);
		data_acc_valid <= 1'b0;
		fetch_valid <= 1'b0;
		data_acc_addr <= ~data_acc_addr;
		fetch_addr <= ~fetch_addr;
	endtask
endmodule
`default_nettype wire

// file: verif/tlbm_reload_props.sv
// port-level checks for the reload assist and invalidate block
`default_nettype none
module tlbm_reload_props (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic data_acc_valid,
	input wire logic data_done,
	input wire logic data_miss,
	input wire logic data_error,
	input wire logic fetch_valid,
	input wire logic fetch_done,
	input wire logic fetch_miss
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// each access is answered one cycle later, with at most one outcome
	property p_data_done;
		data_acc_valid |=> data_done;
	endproperty
	a_data_done: assert property (p_data_done) else $error("data access not answered");
	property p_outcome;
		(data_miss || data_error) |-> data_done && !(data_miss && data_error) && $past(data_acc_valid);
	endproperty
	a_outcome: assert property (p_outcome) else $error("stray or double data outcome");
	property p_fetch_done;
		fetch_valid |=> fetch_done;
	endproperty
	a_fetch_done: assert property (p_fetch_done) else $error("fetch not answered");
	property p_fetch_miss;
		fetch_miss |-> fetch_done && $past(fetch_valid);
	endproperty
	a_fetch_miss: assert property (p_fetch_miss) else $error("fetch miss without fetch");
	// answers hold until the master takes them
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
	property p_w_answer;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid;
	endproperty
	a_w_answer: assert property (p_w_answer) else $error("write not answered");
	property p_w_decerr;
		s_axi_awvalid && s_axi_awready && s_axi_awaddr > 8'h30 |-> ##[1:3] s_axi_bresp == 2'h3;
	endproperty
	a_w_decerr: assert property (p_w_decerr) else $error("unmapped write not refused");
	property p_r_decerr;
		s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h30 |=> s_axi_rresp == 2'h3 && s_axi_rdata == 32'h0;
	endproperty
	a_r_decerr: assert property (p_r_decerr) else $error("unmapped read not refused");
	property p_r_block;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_r_block: assert property (p_r_block) else $error("read taken while answer pending");
endmodule
`default_nettype wire

// file: verif/tlbm_reload_tb.sv
// self-checking bench for the reload assist and invalidate block
`include "tlbm_defs.vh"
`default_nettype none
module tlbm_reload_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, data_acc_addr, fetch_addr, data_phys_addr, fetch_phys_addr;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic data_acc_valid, data_acc_write, data_acc_user, fetch_valid, data_done, data_miss;
	logic data_error, fetch_done, fetch_miss;
	int err_count, compares, seed, i;
	logic [33:0] aq[$], rq[$], bq[$];
	logic [31:0] pa, pb, pc, pg;
	// fault rows {flags, store, user}; the row number is the expected cause bit
	logic [9:0] ftab [3] = '{10'h3C0, 10'h361, 10'h3A2};
	tlbm_reload tlbm_reload_inst (.*);
	tlbm_core_model tlbm_core_model_inst (.*);
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic tmo();
		err_count++;
		$display("BAD %0t wait ran out", $time);
		report_and_stop();
	endtask
	task automatic chk(input logic [33:0] g, input logic [33:0] e, input string what);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("BAD %0t %s got %h want %h", $time, what, g, e);
		end
	endtask
	// one compare per kind of result, each against the oldest note
	task automatic cmp_acc(input logic [33:0] g);
		chk(g, (aq.size() > 0) ? aq.pop_front() : 34'bx, "access");
	endtask
	task automatic cmp_rd(input logic [33:0] g);
		chk(g, (rq.size() > 0) ? rq.pop_front() : 34'bx, "read");
	endtask
	task automatic cmp_b(input logic [33:0] g);
		chk(g, (bq.size() > 0) ? bq.pop_front() : 34'bx, "write response");
	endtask
	always @(posedge aclk) begin
		if (data_done === 1'b1) cmp_acc({data_phys_addr, data_miss, data_error});
		if (fetch_done === 1'b1) cmp_acc({fetch_phys_addr, fetch_miss, 1'b0});
		if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) cmp_rd({s_axi_rresp, s_axi_rdata});
		if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) cmp_b({32'h0, s_axi_bresp});
	end
	// local flags track each channel: the driven lines only update after this time step
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
		int n;
		logic aw_on, w_on, b_on;
		bq.push_back({32'h0, r});
		aw_on = 1'b1;
		w_on = 1'b1;
		b_on = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 40 && (aw_on || w_on || b_on); n++) begin
			@(posedge aclk);
			if (aw_on && s_axi_awready === 1'b1) begin
				s_axi_awvalid <= 1'b0;
				aw_on = 1'b0;
			end
			if (w_on && s_axi_wready === 1'b1) begin
				s_axi_wvalid <= 1'b0;
				w_on = 1'b0;
			end
			if (b_on && s_axi_bvalid === 1'b1) begin
				s_axi_bready <= 1'b0;
				b_on = 1'b0;
			end
		end
		// one idle edge so a following call never re-raises bready in the same step
		@(posedge aclk);
		if (aw_on || w_on || b_on) tmo();
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
		int n;
		logic ar_on, r_on;
		rq.push_back({r, d});
		ar_on = 1'b1;
		r_on = 1'b1;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 40 && (ar_on || r_on); n++) begin
			@(posedge aclk);
			if (ar_on && s_axi_arready === 1'b1) begin
				s_axi_arvalid <= 1'b0;
				ar_on = 1'b0;
			end
			if (r_on && s_axi_rvalid === 1'b1) begin
				s_axi_rready <= 1'b0;
				r_on = 1'b0;
			end
		end
		@(posedge aclk);
		if (ar_on || r_on) tmo();
	endtask
	task automatic acc(input logic [31:0] a, input logic w, u, f, input logic [33:0] e);
		aq.push_back(e);
		tlbm_core_model_inst.access(a, w, u, f);
		@(posedge aclk);
	endtask
	initial begin
		seed = 32'h2ae3;
		aresetn = 1'b0;
		s_axi_awaddr = 8'h0;
		s_axi_awvalid = 1'b0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_araddr = 8'h0;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		pa = $random(seed);
		pb = $random(seed) & 32'hFFFFC000;
		pc = (pa ^ 32'h40000000) & 32'hFFFFC000;
		rd(`TLBM_OFF_MODE, 32'h0);
		rd(8'h34, 32'h0, `TLBM_RESP_DECERR);
		wr(8'h34, 32'h1, `TLBM_RESP_DECERR);
		acc(pa, 1'b0, 1'b0, 1'b0, {pa, 2'b00});
		$display("test reset done");
		wr(`TLBM_OFF_CMD, 32'h1);
		wr(`TLBM_OFF_MODE, 32'h3);
		acc(pa, 1'b0, 1'b0, 1'b0, {pa, 2'b10});
		acc(pb, 1'b0, 1'b0, 1'b1, {pb, 2'b10});
		wr(`TLBM_OFF_MODE, 32'h0);
		rd(`TLBM_OFF_STATUS, 32'h18);
		rd(`TLBM_OFF_DMISS, {pa[31:10], 10'h200});
		rd(`TLBM_OFF_IMISS, {pb[31:10], 10'h200});
		rd(`TLBM_OFF_DCTR, 32'h0);
		wr(`TLBM_OFF_L1PTR, pc);
		rd(`TLBM_OFF_L1PTR, {pc[31:12], pa[31:22], 2'b00});
		wr(`TLBM_OFF_DTWC, pc);
		rd(`TLBM_OFF_DTWC, {pc[31:12], pa[21:12], 2'b00});
		wr(`TLBM_OFF_SCRATCH, pb);
		rd(`TLBM_OFF_SCRATCH, pb);
		wr(`TLBM_OFF_DRPN, {pb[31:12], 12'h0F8});
		rd(`TLBM_OFF_DCTR, 32'h1F00);
		wr(`TLBM_OFF_MODE, 32'h3);
		acc(pa ^ 32'h155, 1'b0, 1'b0, 1'b0, {pb[31:12], pa[11:0] ^ 12'h155, 2'b00});
		$display("test reload done");
		for (i = 0; i < 3; i++) begin
			pg = pa ^ {i[7:0] + 8'h1, 24'h0};
			wr(`TLBM_OFF_STATUS, 32'h1F);
			wr(`TLBM_OFF_DMISS, {pg[31:10], 10'h200});
			wr(`TLBM_OFF_DRPN, {pb[31:12], 4'h0, ftab[i][9:2]});
			acc(pg, ftab[i][1], ftab[i][0], 1'b0, {pb[31:12], pg[11:0], 2'b01});
			rd(`TLBM_OFF_STATUS, 32'h1 << i);
		end
		$display("test faults done");
		wr(`TLBM_OFF_DMISS, {pc[31:10], 10'h205});
		wr(`TLBM_OFF_DRPN, {pb[31:12], 2'h0, `TLBM_PS_16K, 8'hF8});
		acc(pc, 1'b0, 1'b0, 1'b0, {pb[31:12], pc[11:0], 2'b00});
		wr(`TLBM_OFF_INVADDR, pc ^ 32'h1000);
		wr(`TLBM_OFF_CMD, 32'h2);
		wr(`TLBM_OFF_INVADDR, pa ^ 32'h3FF);
		wr(`TLBM_OFF_CMD, 32'h2);
		acc(pc, 1'b0, 1'b0, 1'b0, {pc, 2'b10});
		acc(pa, 1'b0, 1'b0, 1'b0, {pa, 2'b10});
		$display("test single invalidate done");
		wr(`TLBM_OFF_MODE, 32'h0);
		wr(`TLBM_OFF_DCTR, 32'h0);
		wr(`TLBM_OFF_INVADDR, pb);
		wr(`TLBM_OFF_CMD, 32'h2);
		wr(`TLBM_OFF_DCTR, 32'h1E00);
		wr(`TLBM_OFF_DMISS, {pb[31:10], 10'h200});
		wr(`TLBM_OFF_DRPN, {pc[31:12], 12'h0F8});
		wr(`TLBM_OFF_DCTR, 32'h1);
		wr(`TLBM_OFF_CMD, 32'h1);
		wr(`TLBM_OFF_DMISS, {pa[31:10], 10'h200});
		wr(`TLBM_OFF_DRPN, {pb[31:12], 12'h0F8});
		rd(`TLBM_OFF_DCTR, 32'h0501);
		wr(`TLBM_OFF_IMISS, {pa[31:10], 10'h200});
		wr(`TLBM_OFF_IRPN, {pc[31:12], 12'h0F8});
		rd(`TLBM_OFF_ICTR, 32'h1F00);
		wr(`TLBM_OFF_MODE, 32'h3);
		acc(pb, 1'b0, 1'b0, 1'b0, {pc[31:12], pb[11:0], 2'b00});
		acc(pa, 1'b1, 1'b0, 1'b0, {pb[31:12], pa[11:0], 2'b00});
		acc(pa, 1'b0, 1'b0, 1'b1, {pc[31:12], pa[11:0], 2'b00});
		wr(`TLBM_OFF_MODE, 32'h0);
		wr(`TLBM_OFF_DCTR, 32'h1E01);
		wr(`TLBM_OFF_DMISS, {pb[31:10], 10'h000});
		wr(`TLBM_OFF_DRPN, 32'h0);
		wr(`TLBM_OFF_MODE, 32'h3);
		acc(pb, 1'b0, 1'b0, 1'b0, {pb, 2'b10});
		rd(`TLBM_OFF_DCTR, 32'h0501);
		$display("test reserve done");
		repeat (4) @(posedge aclk);
		report_and_stop();
	end
endmodule
bind tlbm_reload tlbm_reload_props tlbm_reload_props_inst (.*);
`default_nettype wire
